// file: rtl/option_byte_pkg.sv
// Constants shared by the option byte fetch and decode logic.
// Assumes one system clock and an active-low asynchronous reset.
`default_nettype none
package option_byte_pkg;
   // Clock rate and detector stabilisation wait
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned DET_STAB_US = 200;
   localparam int unsigned DET_STAB_CYC = DET_STAB_US * CLK_MHZ;
   // Flash areas holding the four option bytes
   localparam logic [19:0] OPT_AREA_MAIN = 20'h000C0;
   localparam logic [19:0] OPT_AREA_SWAP = 20'h010C0;
   localparam logic [1:0] OPT_LAST_IDX = 2'h3;
   // Register indexes; byte address is four times the index
   localparam logic [9:0] IDX_WDOG_OPT = 10'h0C0;
   localparam logic [9:0] IDX_DET_OPT = 10'h0C1;
   localparam logic [9:0] IDX_RSVD_OPT = 10'h0C2;
   localparam logic [9:0] IDX_DBG_OPT = 10'h0C3;
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_MASK = 12'h004;
   localparam logic [11:0] ADDR_CTRL = 12'h008;
   localparam logic [11:0] ADDR_STATE = 12'h00C;
   // Watchdog option byte fields
   localparam int unsigned WD_STBY = 0;
   localparam int unsigned WD_OVF_LO = 1;
   localparam int unsigned WD_ON = 4;
   localparam int unsigned WD_WIN_LO = 5;
   localparam int unsigned WD_INIT = 7;
   localparam logic [1:0] WIN_FULL = 2'h3;
   // Detector, reserved and debug option byte fields
   localparam int unsigned DET_OFF = 0;
   localparam logic [6:0] DET_FIXED = 7'h7F;
   localparam logic [7:0] RSVD_VALUE = 8'hFF;
   localparam int unsigned DBG_NOERASE = 0;
   localparam int unsigned DBG_EN = 7;
   localparam logic [2:0] DBG_FIXED_HI = 3'h0;
   // Event bits of the status and mask registers
   localparam int unsigned EV_LOADED = 0;
   localparam int unsigned EV_DBG_BAD = 1;
   localparam int unsigned EV_FMT_BAD = 2;
   localparam int unsigned EV_INTERVAL = 3;
   localparam int unsigned EV_W = 4;
   localparam logic [3:0] EV_RESET = 4'h0;
   localparam int unsigned CTRL_DET_RUN = 0;
endpackage : option_byte_pkg
`default_nettype wire

// file: rtl/option_fetch.sv
// Reads the four option bytes from flash once after reset.
// Assumes a same-clock flash port: level request, one-cycle ack with data.
`default_nettype none
module option_fetch (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic boot_swap, // Fetch from the alternate area
   output logic flash_req, // Read request, held until last ack
   output logic [19:0] flash_addr, // Byte address of the read
   input wire logic [7:0] flash_rdata, // Read data, valid with ack
   input wire logic flash_ack, // Read answered
   output logic [31:0] opt_word, // Bytes 3..0 as fetched
   output logic opt_load // One-cycle pulse when all four are in
);
   typedef enum logic [1:0] {
      F_START = 2'b00,
      F_READ = 2'b01,
      F_DONE = 2'b11
   } fetch_state_t;

   fetch_state_t state, next_state;
   logic [1:0] idx, next_idx;
   logic next_req, next_load;
   logic [19:0] next_addr;
   logic [31:0] next_word;

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_req = flash_req;
      next_addr = flash_addr;
      next_word = opt_word;
      next_load = 1'b0;
      unique case (state)
         F_START: begin
            next_req = 1'b1;
            next_idx = 2'h0;
            next_addr = boot_swap ? option_byte_pkg::OPT_AREA_SWAP
                                  : option_byte_pkg::OPT_AREA_MAIN;
            next_state = F_READ;
         end
         F_READ: begin
            if (flash_ack) begin
               next_word[idx*8 +: 8] = flash_rdata;
               if (idx == option_byte_pkg::OPT_LAST_IDX) begin
                  next_req = 1'b0;
                  next_load = 1'b1;
                  next_state = F_DONE;
               end else begin
                  next_idx = idx + 2'h1;
                  next_addr = {flash_addr[19:2], next_idx};
               end
            end
         end
         F_DONE: begin
         end
         default: next_state = F_DONE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= F_START;
         idx <= 2'h0;
         flash_req <= 1'b0;
         flash_addr <= 20'h00000;
         opt_word <= 32'hFFFFFFFF;
         opt_load <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         idx <= next_idx;
         flash_req <= next_req;
         flash_addr <= next_addr;
         opt_word <= next_word;
         opt_load <= next_load;
      end
   end

   a_fetch_area: assert property (
      @(posedge pclk) disable iff (!presetn) flash_req
      |-> (flash_addr[19:2] == option_byte_pkg::OPT_AREA_MAIN[19:2]
      || flash_addr[19:2] == option_byte_pkg::OPT_AREA_SWAP[19:2]))
      else $error("option fetch outside both option areas");
   a_fetch_once: assert property (
      @(posedge pclk) disable iff (!presetn)
      opt_load |=> !flash_req && state == F_DONE)
      else $error("option fetch did not stop after the last byte");
endmodule : option_fetch
`default_nettype wire

// file: rtl/option_byte_config_decoder.sv
// Option byte decoder: fetches the option bytes at reset and turns them
// into static watchdog, detector and debug settings, with an APB slave.
// Assumes all inputs are synchronous to pclk.
//
// Register access over APB was left to the implementer.
`default_nettype none
module option_byte_config_decoder #(
   parameter int unsigned DET_STAB_CYC = option_byte_pkg::DET_STAB_CYC
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic boot_swap, // Boot swap active
   output logic flash_req, // Flash read request
   output logic [19:0] flash_addr, // Flash byte address
   input wire logic [7:0] flash_rdata, // Flash read data
   input wire logic flash_ack, // Flash read answered
   input wire logic fast_restart, // Last reset was watchdog/illegal op
   input wire logic cpu_standby, // Processor in halt or stop
   input wire logic selfprog_busy, // Self-programming in progress
   input wire logic [19:0] wdog_count, // Watchdog counter value
   output logic config_valid, // Settings decoded
   output logic standby_wdog_run, // Watchdog counts in standby
   output logic wdog_counter_enable, // Watchdog counter enabled
   output logic wdog_count_gate, // Watchdog may count this cycle
   output logic [1:0] open_span_sel, // Window: 0=25 1=50 2=75 3=100 %
   output logic interval_irq_use, // Interval interrupt used
   output logic [4:0] overflow_exp, // Overflow period as power of two
   output logic wdog_interval_irq, // Counter reached 75 percent
   output logic detector_default_disable, // Detector off by default
   output logic detector_run_enable, // Detector run-enable
   output logic detector_stable, // Detector stabilisation over
   output logic detector_detect_active, // Detection in effect
   output logic debug_enable, // On-chip debug enabled
   output logic no_erase_on_auth_fail, // Keep flash on failed auth
   output logic debug_setting_bad, // Prohibited debug pattern
   output logic irq // Interrupt, level
);
   localparam int unsigned W = option_byte_pkg::EV_W;

   logic [31:0] opt_word;
   logic opt_load;
   logic [7:0] wdog_opt, det_opt, rsvd_opt, dbg_opt;

   assign wdog_opt = opt_word[7:0];
   assign det_opt = opt_word[15:8];
   assign rsvd_opt = opt_word[23:16];
   assign dbg_opt = opt_word[31:24];

   option_fetch u_fetch (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .boot_swap(boot_swap),
      .flash_req(flash_req),
      .flash_addr(flash_addr),
      .flash_rdata(flash_rdata),
      .flash_ack(flash_ack),
      .opt_word(opt_word),
      .opt_load(opt_load)
   );

   function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
      logic [4:0] e;
      e = 5'h0A;
      unique case (sel)
         3'h0: e = 5'h0A;
         3'h1: e = 5'h0B;
         3'h2: e = 5'h0C;
         3'h3: e = 5'h0D;
         3'h4: e = 5'h0F;
         3'h5: e = 5'h11;
         3'h6: e = 5'h12;
         3'h7: e = 5'h14;
      endcase
      return e;
   endfunction : ovf_exp

   // Decoded settings, loaded once per reset
   logic next_valid, next_stby, next_wdon, next_init, next_det_off;
   logic next_dbg_en, next_noerase, next_dbg_bad;
   logic [1:0] next_span;
   logic [4:0] next_exp;
   logic [19:0] interval_at, next_interval_at;
   logic [20:0] full_span;

   always_comb begin
      next_valid = config_valid;
      next_stby = standby_wdog_run;
      next_wdon = wdog_counter_enable;
      next_span = open_span_sel;
      next_init = interval_irq_use;
      next_exp = overflow_exp;
      next_interval_at = interval_at;
      next_det_off = detector_default_disable;
      next_dbg_en = debug_enable;
      next_noerase = no_erase_on_auth_fail;
      next_dbg_bad = debug_setting_bad;
      full_span = 21'h000001
         << ovf_exp(wdog_opt[option_byte_pkg::WD_OVF_LO +: 3]);
      // Only a fetch pulse updates these; software cannot touch them
      if (opt_load) begin
         next_valid = 1'b1;
         next_stby = wdog_opt[option_byte_pkg::WD_STBY];
         next_wdon = wdog_opt[option_byte_pkg::WD_ON];
         next_span = wdog_opt[option_byte_pkg::WD_WIN_LO +: 2];
         if (!wdog_opt[option_byte_pkg::WD_STBY]) begin
            next_span = option_byte_pkg::WIN_FULL;
         end
         next_init = wdog_opt[option_byte_pkg::WD_INIT];
         next_exp = ovf_exp(
            wdog_opt[option_byte_pkg::WD_OVF_LO +: 3]);
         next_interval_at = 20'(full_span - (full_span >> 2));
         next_det_off = det_opt[option_byte_pkg::DET_OFF];
         // Bits 3..1 may be rewritten by the debugger, so only 7 and 0 count
         next_dbg_en = dbg_opt[option_byte_pkg::DBG_EN];
         next_noerase = dbg_opt[option_byte_pkg::DBG_EN]
            & dbg_opt[option_byte_pkg::DBG_NOERASE];
         next_dbg_bad = !dbg_opt[option_byte_pkg::DBG_EN]
            & dbg_opt[option_byte_pkg::DBG_NOERASE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_valid <= 1'b0;
         standby_wdog_run <= 1'b0;
         wdog_counter_enable <= 1'b0;
         open_span_sel <= option_byte_pkg::WIN_FULL;
         interval_irq_use <= 1'b0;
         overflow_exp <= 5'h0A;
         interval_at <= 20'h00000;
         detector_default_disable <= 1'b1;
         debug_enable <= 1'b0;
         no_erase_on_auth_fail <= 1'b0;
         debug_setting_bad <= 1'b0;
      end else if (clk_en) begin
         config_valid <= next_valid;
         standby_wdog_run <= next_stby;
         wdog_counter_enable <= next_wdon;
         open_span_sel <= next_span;
         interval_irq_use <= next_init;
         overflow_exp <= next_exp;
         interval_at <= next_interval_at;
         detector_default_disable <= next_det_off;
         debug_enable <= next_dbg_en;
         no_erase_on_auth_fail <= next_noerase;
         debug_setting_bad <= next_dbg_bad;
      end
   end

   // Watchdog gating and interval event
   logic next_gate, next_interval;

   always_comb begin
      // Self-programming deliberately does not enter this gate
      next_gate = wdog_counter_enable
         & (!cpu_standby | standby_wdog_run);
      next_interval = interval_irq_use & wdog_counter_enable
         & (wdog_count == interval_at);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_count_gate <= 1'b0;
         wdog_interval_irq <= 1'b0;
      end else if (clk_en) begin
         wdog_count_gate <= next_gate;
         wdog_interval_irq <= next_interval;
      end
   end

   // Detector run-enable and stabilisation
   logic [15:0] stab_cnt, next_stab_cnt;
   logic next_run, next_stable, next_active;
   logic ctrl_wr, access;

   assign access = psel & penable & pready;
   assign ctrl_wr = access & pwrite & (paddr == option_byte_pkg::ADDR_CTRL);

   always_comb begin
      next_run = detector_run_enable;
      next_stable = detector_stable;
      next_stab_cnt = stab_cnt;
      if (opt_load) begin
         // Default start re-arms run-enable even if software cleared it
         next_run = !det_opt[option_byte_pkg::DET_OFF];
         // Fast restarts skip the wait: short glitches may go unseen
         next_stable = fast_restart;
         next_stab_cnt = 16'(DET_STAB_CYC);
      end else begin
         if (ctrl_wr && config_valid) begin
            next_run = pwdata[option_byte_pkg::CTRL_DET_RUN];
         end
         if (config_valid && !detector_stable) begin
            if (stab_cnt <= 16'h0001) begin
               next_stable = 1'b1;
            end else begin
               next_stab_cnt = stab_cnt - 16'h0001;
            end
         end
      end
      next_active = next_run & next_stable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detector_run_enable <= 1'b0;
         detector_stable <= 1'b0;
         detector_detect_active <= 1'b0;
         stab_cnt <= 16'h0000;
      end else if (clk_en) begin
         detector_run_enable <= next_run;
         detector_stable <= next_stable;
         detector_detect_active <= next_active;
         stab_cnt <= next_stab_cnt;
      end
   end

   // APB slave, status/mask interrupt logic
   logic [W-1:0] status, next_status, mask, next_mask, events;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq, setup, hit, fmt_bad;

   assign setup = psel & !penable;
   // Format checks for bytes the programmer must fill correctly
   assign fmt_bad = (det_opt[7:1] != option_byte_pkg::DET_FIXED)
      | (rsvd_opt != option_byte_pkg::RSVD_VALUE)
      | (dbg_opt[6:4] != option_byte_pkg::DBG_FIXED_HI);

   always_comb begin
      events = '0;
      events[option_byte_pkg::EV_LOADED] = opt_load;
      events[option_byte_pkg::EV_DBG_BAD] = opt_load
         & !dbg_opt[option_byte_pkg::DBG_EN]
         & dbg_opt[option_byte_pkg::DBG_NOERASE];
      events[option_byte_pkg::EV_FMT_BAD] = opt_load & fmt_bad;
      events[option_byte_pkg::EV_INTERVAL] = wdog_interval_irq;
      next_mask = mask;
      next_status = status;
      if (access && pwrite && paddr == option_byte_pkg::ADDR_MASK) begin
         next_mask = pwdata[W-1:0];
      end
      if (access && pwrite && paddr == option_byte_pkg::ADDR_STATUS) begin
         next_status = status & ~pwdata[W-1:0];
      end
      // A new event wins over a clear in the same cycle
      next_status = next_status | events;
      next_irq = |(next_status & next_mask);
      hit = 1'b1;
      next_prdata = 32'h00000000;
      unique case (paddr)
         {option_byte_pkg::IDX_WDOG_OPT, 2'b00}: next_prdata[7:0] = wdog_opt;
         {option_byte_pkg::IDX_DET_OPT, 2'b00}: next_prdata[7:0] = det_opt;
         {option_byte_pkg::IDX_RSVD_OPT, 2'b00}: next_prdata[7:0] = rsvd_opt;
         {option_byte_pkg::IDX_DBG_OPT, 2'b00}: next_prdata[7:0] = dbg_opt;
         option_byte_pkg::ADDR_STATUS: next_prdata[W-1:0] = status;
         option_byte_pkg::ADDR_MASK: next_prdata[W-1:0] = mask;
         option_byte_pkg::ADDR_CTRL: next_prdata[0] = detector_run_enable;
         option_byte_pkg::ADDR_STATE: next_prdata[7:0] = {config_valid,
            detector_stable, detector_detect_active, debug_enable,
            no_erase_on_auth_fail, debug_setting_bad, wdog_count_gate,
            boot_swap};
         default: hit = 1'b0;
      endcase
      if (!setup) begin
         next_prdata = prdata;
      end
      next_pready = setup;
      next_pslverr = setup & !hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= option_byte_pkg::EV_RESET;
         mask <= option_byte_pkg::EV_RESET;
         irq <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         status <= next_status;
         mask <= next_mask;
         irq <= next_irq;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_window_full: assert property (
      !standby_wdog_run |-> open_span_sel == 2'h3)
      else $error("window not full with standby run off");
   a_standby_stop: assert property (
      clk_en && cpu_standby && !standby_wdog_run |=> !wdog_count_gate)
      else $error("watchdog counts in standby");
   a_selfprog_run: assert property (
      clk_en && wdog_counter_enable && !cpu_standby && selfprog_busy
      |=> wdog_count_gate)
      else $error("watchdog paused during self-programming");
   a_window_map: assert property (
      opt_load && clk_en && wdog_opt[0]
      |=> open_span_sel == $past(wdog_opt[6:5]))
      else $error("window select mismatch");
   a_interval_off: assert property (
      !interval_irq_use |=> !wdog_interval_irq)
      else $error("interval interrupt while unused");
   a_ovf_map: assert property (
      config_valid |-> overflow_exp == ovf_exp(wdog_opt[3:1]))
      else $error("overflow period mismatch");
   a_det_default: assert property (
      opt_load && clk_en |=> detector_run_enable == !$past(det_opt[0]))
      else $error("detector default start wrong");
   a_detect_gate: assert property (
      detector_detect_active |-> detector_run_enable)
      else $error("detection while run-enable low");
   a_fast_stable: assert property (
      opt_load && clk_en && fast_restart |=> detector_stable)
      else $error("stabilisation wait not skipped");
   a_debug_off: assert property (
      config_valid && !dbg_opt[7]
      |-> !debug_enable && !no_erase_on_auth_fail)
      else $error("debug enabled by pattern 0x");
   a_erase_pol: assert property (
      config_valid && debug_enable |-> no_erase_on_auth_fail == dbg_opt[0])
      else $error("erase policy mismatch");
   a_static_hold: assert property (
      config_valid && $past(config_valid) |-> $stable(debug_enable)
      && $stable(overflow_exp) && $stable(open_span_sel))
      else $error("decoded setting changed after load");
   a_apb_answer: assert property (clk_en && setup |=> pready)
      else $error("apb access not answered");
endmodule : option_byte_config_decoder
`default_nettype wire

// file: testbench/flash_model.sv
// Behavioural flash holding the main and alternate option byte areas.
// Assumes a request level that is held until each one-cycle ack.
`default_nettype none
module flash_model (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic slow, // Adds wait cycles before each ack
   input wire logic [31:0] main_bytes, // Bytes at 0x000C0..0x000C3
   input wire logic [31:0] swap_bytes, // Bytes at 0x010C0..0x010C3
   input wire logic flash_req, // Read request
   input wire logic [19:0] flash_addr, // Byte address
   output logic [7:0] flash_rdata, // Read data
   output logic flash_ack // Answer pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_cnt;
   logic [31:0] area;
   assign area = flash_addr[12] ? swap_bytes : main_bytes;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 3'h0;
         flash_ack <= 1'b0;
         flash_rdata <= 8'h00;
      end else begin
         flash_ack <= 1'b0;
         // Stale data toggles so a late capture cannot pass by luck
         flash_rdata <= ~flash_rdata;
         if (flash_req && !flash_ack) begin
            wait_cnt <= wait_cnt + 3'h1;
            if (wait_cnt >= (slow ? 3'h4 : 3'h1)) begin
               flash_ack <= 1'b1;
               flash_rdata <= area[{flash_addr[1:0], 3'h0} +: 8];
               wait_cnt <= 3'h0;
            end
         end
      end
   end
endmodule : flash_model
`default_nettype wire

// file: testbench/tb_option_byte_config_decoder.sv
// Testbench: option bytes from a flash model, checks of decoded outputs.
// Assumes the APB slave answers with pready; all waits are bounded.
`default_nettype none
module tb_option_byte_config_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [31:0] opt;
      logic swap;
      logic [1:0] span;
      logic [4:0] oexp;
      logic [6:0] flg;
   } row_t;
   // Flags: stby, counter on, irq use, det off, debug, no erase, bad
   // Fixed bits kept as programmed, except the reserved byte of row 4,
   // which is spoiled on purpose to raise the format event
   row_t rows [10] = '{
      '{32'h85FFFF10, 1'h0, 2'h3, 5'h0A, 7'h2E},
      '{32'h84FFFE91, 1'h1, 2'h0, 5'h0A, 7'h74},
      '{32'h04FFFF33, 1'h0, 2'h1, 5'h0B, 7'h68},
      '{32'h05FFFF45, 1'h1, 2'h2, 5'h0C, 7'h49},
      '{32'h04FEFF77, 1'h0, 2'h3, 5'h0D, 7'h68},
      '{32'h04FFFF79, 1'h0, 2'h3, 5'h0F, 7'h68},
      '{32'h04FFFF7B, 1'h0, 2'h3, 5'h11, 7'h68},
      '{32'h04FFFF7D, 1'h0, 2'h3, 5'h12, 7'h68},
      '{32'h04FFFF7F, 1'h0, 2'h3, 5'h14, 7'h68},
      '{32'h8FFFFE90, 1'h0, 2'h3, 5'h0A, 7'h36}};
   row_t r;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, boot_swap = 1'b0, fast_restart = 1'b0;
   logic cpu_standby = 1'b0, selfprog_busy = 1'b0, slow = 1'b0, clk_en = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, main_b = 32'h0, swap_b = 32'h0;
   logic [19:0] wdog_count = 20'h0;
   wire logic [31:0] prdata;
   wire logic [19:0] flash_addr;
   wire logic [7:0] flash_rdata;
   wire logic [4:0] overflow_exp;
   wire logic [1:0] open_span_sel;
   wire logic pready, pslverr, flash_req, flash_ack, config_valid, irq;
   wire logic standby_wdog_run, wdog_counter_enable, wdog_count_gate;
   wire logic interval_irq_use, wdog_interval_irq, detector_default_disable;
   wire logic detector_run_enable, detector_stable, detector_detect_active;
   wire logic debug_enable, no_erase_on_auth_fail, debug_setting_bad;
   int errors = 0, n_tests = 0;
   always #2 pclk = ~pclk;
   // Short stabilisation count keeps the run brief
   option_byte_config_decoder #(.DET_STAB_CYC(20))
      option_byte_config_decoder_i (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_swap(boot_swap), .flash_req(flash_req), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .flash_ack(flash_ack),
      .fast_restart(fast_restart), .cpu_standby(cpu_standby),
      .selfprog_busy(selfprog_busy), .wdog_count(wdog_count),
      .config_valid(config_valid), .standby_wdog_run(standby_wdog_run),
      .wdog_counter_enable(wdog_counter_enable),
      .wdog_count_gate(wdog_count_gate), .open_span_sel(open_span_sel),
      .interval_irq_use(interval_irq_use), .overflow_exp(overflow_exp),
      .wdog_interval_irq(wdog_interval_irq),
      .detector_default_disable(detector_default_disable),
      .detector_run_enable(detector_run_enable),
      .detector_stable(detector_stable),
      .detector_detect_active(detector_detect_active),
      .debug_enable(debug_enable),
      .no_erase_on_auth_fail(no_erase_on_auth_fail),
      .debug_setting_bad(debug_setting_bad), .irq(irq));
   flash_model flash_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
      .main_bytes(main_b), .swap_bytes(swap_b), .flash_req(flash_req),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata),
      .flash_ack(flash_ack));
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         errors++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 200; i++) begin
         @(posedge pclk);
         if (config_valid === 1'b1) return;
      end
      chk(1'b0, "settings never loaded");
      close_out();
   endtask : do_reset
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            return;
         end
      end
      chk(1'b0, "no pready");
      close_out();
   endtask : apb
   initial begin
      logic [31:0] rd;
      logic er;
      int p;
      for (int k = 0; k < 10; k++) begin
         r = rows[k];
         boot_swap <= r.swap;
         main_b <= r.swap ? ~r.opt : r.opt;
         swap_b <= r.swap ? r.opt : ~r.opt;
         slow <= k[0];
         do_reset();
         chk(open_span_sel === r.span, "window");
         chk(overflow_exp === r.oexp, "overflow");
         chk({standby_wdog_run, wdog_counter_enable, interval_irq_use,
            detector_default_disable, debug_enable, no_erase_on_auth_fail,
            debug_setting_bad}
            === r.flg, "flags");
         chk(detector_run_enable === ~r.flg[3], "det run");
         apb(1'b0, 12'h300, 32'h0, rd, er);
         chk(rd === {24'h0, r.opt[7:0]}, "byte0 read");
         apb(1'b0, 12'h000, 32'h0, rd, er);
         chk(rd[2:0] === {r.opt[23:16] != 8'hFF, r.flg[0], 1'b1}
            && rd[31:3] === 29'h0, "status");
         $display("test row %0d done", k);
      end
      apb(1'b1, 12'h300, 32'h0, rd, er);
      apb(1'b0, 12'h300, 32'h0, rd, er);
      chk(rd === 32'h90 && open_span_sel === 2'h3, "static");
      apb(1'b0, 12'h100, 32'h0, rd, er);
      chk(er === 1'b1 && rd === 32'h0, "unmapped");
      $display("test registers done");
      cpu_standby <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(wdog_count_gate === 1'b0, "standby gate");
      cpu_standby <= 1'b0;
      selfprog_busy <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(wdog_count_gate === 1'b1, "selfprog gate");
      wdog_count <= 20'h00300;
      @(posedge pclk);
      wdog_count <= 20'h0;
      p = 0;
      repeat (5) @(posedge pclk) p += (wdog_interval_irq === 1'b1);
      chk(p == 1 && irq === 1'b0, "interval pulse");
      apb(1'b1, 12'h004, 32'h8, rd, er);
      repeat (2) @(posedge pclk);
      chk(irq === 1'b1, "irq masked in");
      apb(1'b1, 12'h000, 32'h8, rd, er);
      repeat (2) @(posedge pclk);
      chk(irq === 1'b0, "irq cleared");
      $display("test events done");
      apb(1'b1, 12'h008, 32'h0, rd, er);
      repeat (2) @(posedge pclk);
      chk(detector_run_enable === 1'b0, "run off");
      chk(detector_detect_active === 1'b0, "no detect");
      do_reset();
      chk(detector_run_enable === 1'b1, "run re-set");
      chk(detector_stable === 1'b0, "stab wait");
      // A low clock enable must hold the stabilisation count still
      clk_en <= 1'b0;
      repeat (25) @(posedge pclk);
      chk(detector_detect_active === 1'b0, "frozen");
      clk_en <= 1'b1;
      repeat (25) @(posedge pclk);
      chk(detector_detect_active === 1'b1, "detect");
      fast_restart <= 1'b1;
      do_reset();
      repeat (2) @(posedge pclk);
      chk(detector_stable === 1'b1, "fast start");
      $display("test detector done");
      close_out();
   end
endmodule : tb_option_byte_config_decoder
`default_nettype wire
